// ### inc/cbc_pkg.sv
/*
 Constants of the colour balance controller: register address, field
 positions, gain limits, run length and timeout.
 Assumes a 200 MHz camera clock and a 32-bit register word, bit 31 = MSB.
*/
package cbc_pkg;
	// ----------------------------------------
	// Register address and field positions
	// ----------------------------------------
	localparam logic [31:0] CBC_REG_ADDR = 32'hf0f0080c;
	localparam int CBC_PRES_BIT = 31;
	localparam int CBC_ABS_BIT = 30;
	localparam int CBC_ONE_BIT = 26;
	localparam int CBC_ON_BIT = 25;
	localparam int CBC_AM_BIT = 24;
	localparam int CBC_GAIN_W = 12;
	localparam int CBC_UB_LSB = 12;
	localparam int CBC_VR_LSB = 0;
	localparam logic [2:0] CBC_RSVD = 3'h0;
	// ----------------------------------------
	// Gain codes
	// ----------------------------------------
	localparam logic [CBC_GAIN_W-1:0] CBC_GAIN_MAX = 12'h238;
	localparam logic [CBC_GAIN_W-1:0] CBC_GAIN_MID = 12'h11c;
	localparam logic [CBC_GAIN_W-1:0] CBC_GAIN_STEP = 12'h001;
	localparam real CBC_STEP_DB = 0.0353;
	// ----------------------------------------
	// Run length and timing
	// ----------------------------------------
	localparam int CBC_CNT_W = 4;
	localparam logic [CBC_CNT_W-1:0] CBC_RUN_LAST = 4'h8;
	localparam longint CBC_CLK_HZ = 200000000;
	localparam longint CBC_TIMEOUT_S = 10;
	localparam longint CBC_TIMEOUT_CYC = CBC_TIMEOUT_S * CBC_CLK_HZ;
	typedef enum logic {CBC_IDLE, CBC_RUN} cbc_state_e;
endpackage : cbc_pkg

// ### design/cbc_color_balance.sv
/*
 Colour balance controller: control/status word, one-shot and continuous
 balancing from windowed R/G/B sums, timeout on a stalled frame stream in continuous mode.
 Assumes register strobes and pixel stream come from logic on the same
 clock; frame_end is a pulse in the cycle after the last pixel.
*/
`timescale 1ns/100ps
module cbc_color_balance
	import cbc_pkg::*;
#(
	parameter int PIX_W = 8,
	parameter int COORD_W = 16,
	parameter int SUM_W = 40,
	parameter longint TIMEOUT_CYC = cbc_pkg::CBC_TIMEOUT_CYC
)(
	input wire logic clock, // Camera clock, 200 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [31:0] reg_addr, // Register address
	input wire logic [31:0] reg_wdata, // Write data
	output logic [31:0] reg_rdata, // Read data
	output logic reg_rack, // Read data valid
	input wire logic [cbc_pkg::CBC_GAIN_W-1:0] abs_ub, // Absolute blue-side gain
	input wire logic [cbc_pkg::CBC_GAIN_W-1:0] abs_vr, // Absolute red-side gain
	input wire logic stream_transmit_enable, // Stream output on
	input wire logic capture_active, // Capture running
	input wire logic frame_start, // First pixel of frame
	input wire logic frame_end, // Frame finished
	input wire logic pix_valid, // Pixel valid
	input wire logic [COORD_W-1:0] pix_x, // Pixel column
	input wire logic [COORD_W-1:0] pix_y, // Pixel row
	input wire logic [PIX_W-1:0] pix_r, // Red sample
	input wire logic [PIX_W-1:0] pix_g, // Green sample
	input wire logic [PIX_W-1:0] pix_b, // Blue sample
	input wire logic window_enable, // Measurement window on
	input wire logic [COORD_W-1:0] win_x, // Window left
	input wire logic [COORD_W-1:0] win_y, // Window top
	input wire logic [COORD_W-1:0] win_w, // Window width
	input wire logic [COORD_W-1:0] win_h, // Window height
	input wire logic [COORD_W-1:0] img_x, // Image left
	input wire logic [COORD_W-1:0] img_y, // Image top
	input wire logic [COORD_W-1:0] img_w, // Image width
	input wire logic [COORD_W-1:0] img_h, // Image height
	output logic [cbc_pkg::CBC_GAIN_W-1:0] gain_ub, // Applied blue gain
	output logic [cbc_pkg::CBC_GAIN_W-1:0] gain_vr, // Applied red gain
	output logic [cbc_pkg::CBC_GAIN_W-1:0] gain_green, // Applied green gain
	output logic frame_request, // Self-generated frames
	output logic transmit_frames, // Send run frames out
	output logic capture_restart, // Restart capture pulse
	output logic balance_busy // One-shot run active
);
	import cbc_pkg::*;

	if (PIX_W < 1 || COORD_W < 1 || SUM_W < PIX_W + 2 || TIMEOUT_CYC < 2
		|| TIMEOUT_CYC >= 64'h100000000)
	begin : g_bad_param
		$error("cbc_color_balance: unsupported parameter values");
	end

	localparam logic [31:0] TMO_LAST = 32'(TIMEOUT_CYC - 1);

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	cbc_state_e state_reg, state_next;
	logic abs_reg, on_reg, am_reg, tx_reg, was_cap_reg;
	logic [CBC_GAIN_W-1:0] ub_reg, vr_reg, ub_next, vr_next;
	logic [CBC_CNT_W-1:0] cnt_reg;
	logic [31:0] tmr_reg;
	logic [SUM_W-1:0] sr_reg, sg_reg, sb_reg;

	wire hit = reg_addr == CBC_REG_ADDR;
	wire wr_hit = reg_wr && hit;
	wire rd_hit = reg_rd && hit;
	wire run = state_reg == CBC_RUN;
	wire w_one = reg_wdata[CBC_ONE_BIT];
	wire w_am = reg_wdata[CBC_AM_BIT];
	wire start = wr_hit && w_one && !w_am;
	wire val_we = wr_hit && on_reg && !am_reg && !run;
	wire [CBC_GAIN_W-1:0] w_ub = reg_wdata[CBC_UB_LSB +: CBC_GAIN_W];
	wire [CBC_GAIN_W-1:0] w_vr = reg_wdata[CBC_VR_LSB +: CBC_GAIN_W];
	wire [31:0] rd_word = {1'b1, abs_reg, CBC_RSVD, run, on_reg, am_reg,
		ub_reg, vr_reg};

	// ----------------------------------------
	// Measurement window and sums
	// ----------------------------------------
	wire [COORD_W-1:0] ax = window_enable ? win_x : img_x;
	wire [COORD_W-1:0] ay = window_enable ? win_y : img_y;
	wire [COORD_W-1:0] aw = window_enable ? win_w : img_w;
	wire [COORD_W-1:0] ah = window_enable ? win_h : img_h;
	// Offsets avoid the overflow that x+w would suffer near the edge
	wire [COORD_W-1:0] dx = pix_x - ax;
	wire [COORD_W-1:0] dy = pix_y - ay;
	wire in_win = pix_x >= ax && dx < aw && pix_y >= ay && dy < ah;
	wire take = pix_valid && in_win;
	wire [SUM_W-1:0] add_r = take ? SUM_W'(pix_r) : '0;
	wire [SUM_W-1:0] add_g = take ? SUM_W'(pix_g) : '0;
	wire [SUM_W-1:0] add_b = take ? SUM_W'(pix_b) : '0;
	wire [SUM_W-1:0] base_r = frame_start ? '0 : sr_reg;
	wire [SUM_W-1:0] base_g = frame_start ? '0 : sg_reg;
	wire [SUM_W-1:0] base_b = frame_start ? '0 : sb_reg;

	// ----------------------------------------
	// Correction step
	// ----------------------------------------
	// One code per frame: slow, but it can never overshoot by more
	// than a step and needs no divider.
	wire adjust = frame_end && (run || (am_reg && on_reg));
	wire ub_up = sb_reg < sg_reg && ub_reg < CBC_GAIN_MAX;
	wire ub_dn = sb_reg > sg_reg && ub_reg != '0;
	wire vr_up = sr_reg < sg_reg && vr_reg < CBC_GAIN_MAX;
	wire vr_dn = sr_reg > sg_reg && vr_reg != '0;
	wire [CBC_GAIN_W-1:0] w_ub_c = w_ub > CBC_GAIN_MAX ? CBC_GAIN_MAX : w_ub;
	wire [CBC_GAIN_W-1:0] w_vr_c = w_vr > CBC_GAIN_MAX ? CBC_GAIN_MAX : w_vr;

	always_comb
	begin
		ub_next = ub_reg;
		vr_next = vr_reg;
		if (adjust)
		begin
			if (ub_up)
				ub_next = ub_reg + CBC_GAIN_STEP;
			else if (ub_dn)
				ub_next = ub_reg - CBC_GAIN_STEP;
			if (vr_up)
				vr_next = vr_reg + CBC_GAIN_STEP;
			else if (vr_dn)
				vr_next = vr_reg - CBC_GAIN_STEP;
		end
		else if (val_we)
		begin
			ub_next = w_ub_c;
			vr_next = w_vr_c;
		end
	end

	// ----------------------------------------
	// One-shot sequencing
	// ----------------------------------------
	wire finish = run && frame_end && cnt_reg == CBC_RUN_LAST;
	wire tmo = am_reg && on_reg && tmr_reg == TMO_LAST;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			CBC_IDLE:
				if (start)
					state_next = CBC_RUN;
			CBC_RUN:
				if (finish && !start)
					state_next = CBC_IDLE;
		endcase
	end

	// Applied gains: absolute inputs override the stored fields
	wire [CBC_GAIN_W-1:0] app_ub = abs_reg ? abs_ub : ub_reg;
	wire [CBC_GAIN_W-1:0] app_vr = abs_reg ? abs_vr : vr_reg;
	wire both_low = app_ub < CBC_GAIN_MID && app_vr < CBC_GAIN_MID;
	wire [CBC_GAIN_W-1:0] app_min = app_ub < app_vr ? app_ub : app_vr;
	wire [CBC_GAIN_W-1:0] app_g = both_low ? app_min : CBC_GAIN_MID;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= CBC_IDLE;
			ub_reg <= CBC_GAIN_MID;
			vr_reg <= CBC_GAIN_MID;
			cnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			ub_reg <= ub_next;
			vr_reg <= vr_next;
			if (start)
				cnt_reg <= '0;
			else if (run && frame_end)
				cnt_reg <= cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			abs_reg <= 1'b0;
			on_reg <= 1'b0;
			am_reg <= 1'b0;
		end
		else if (wr_hit)
		begin
			abs_reg <= reg_wdata[CBC_ABS_BIT];
			on_reg <= reg_wdata[CBC_ON_BIT];
			am_reg <= w_am;
		end
		else if (tmo)
			am_reg <= 1'b0;
	end

	// Stall timer restarts on every frame, so a trigger gap shows directly
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			tmr_reg <= '0;
		else if (frame_end || !am_reg || !on_reg || wr_hit)
			tmr_reg <= '0;
		else
			tmr_reg <= tmr_reg + 32'h1;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sr_reg <= '0;
			sg_reg <= '0;
			sb_reg <= '0;
		end
		else
		begin
			sr_reg <= base_r + add_r;
			sg_reg <= base_g + add_g;
			sb_reg <= base_b + add_b;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tx_reg <= 1'b0;
			was_cap_reg <= 1'b0;
			capture_restart <= 1'b0;
		end
		else
		begin
			if (start && !run)
			begin
				tx_reg <= stream_transmit_enable;
				was_cap_reg <= capture_active;
			end
			else if (finish && !start)
				tx_reg <= 1'b0;
			capture_restart <= finish && !start && was_cap_reg;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata <= '0;
			reg_rack <= 1'b0;
			gain_ub <= CBC_GAIN_MID;
			gain_vr <= CBC_GAIN_MID;
			gain_green <= CBC_GAIN_MID;
		end
		else
		begin
			reg_rack <= reg_rd;
			reg_rdata <= rd_hit ? rd_word : '0;
			gain_ub <= app_ub;
			gain_vr <= app_vr;
			gain_green <= app_g;
		end
	end

	assign frame_request = run;
	assign balance_busy = run;
	assign transmit_frames = tx_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_presence_bit: assert property (rd_hit |=> reg_rack && reg_rdata[CBC_PRES_BIT])
		else $error("presence bit not read as one");
	a_abs_select: assert property (abs_reg && $stable(abs_reg) |=> gain_ub == $past(abs_ub))
		else $error("absolute gain not applied");
	a_oneshot_start: assert property (start |=> run ##0 balance_busy)
		else $error("one-shot run did not start");
	a_auto_ignores: assert property (wr_hit && w_one && w_am && !run |=> !run)
		else $error("one-shot started in automatic mode");
	a_onoff_write: assert property (wr_hit |=> on_reg == $past(reg_wdata[CBC_ON_BIT]))
		else $error("on/off bit not taken");
	a_mode_write: assert property (wr_hit |=> am_reg == $past(w_am))
		else $error("mode bit not taken");
	a_value_discard: assert property (wr_hit && (am_reg || !on_reg) && !adjust
		|=> ub_reg == $past(ub_reg) && vr_reg == $past(vr_reg))
		else $error("gain write not discarded");
	a_green_min: assert property (both_low |=> gain_green == $past(app_min))
		else $error("green gain not the smaller field");
	a_gain_range: assert property (ub_reg <= CBC_GAIN_MAX && vr_reg <= CBC_GAIN_MAX)
		else $error("gain outside range");
	a_nine_frames: assert property ($fell(run) |-> $past(cnt_reg) == CBC_RUN_LAST)
		else $error("run ended after wrong frame count");
	a_restart_cap: assert property (finish && !start |=> capture_restart == was_cap_reg)
		else $error("capture restart wrong");
	a_auto_abort: assert property (tmo && !wr_hit |=> !am_reg)
		else $error("automatic mode not aborted");

	c_run_done: cover property (start ##[1:1000] finish);
	c_auto_step: cover property (am_reg && adjust && ub_up);
	c_abort: cover property (tmo);
	c_restart: cover property (capture_restart);
endmodule : cbc_color_balance

// ### sim/cbc_frame_src.sv
/*
 Sensor-side frame source: 4x2 pixel frames while run is high, column 0 bright blue.
 Assumes the consumer samples every output on the rising clock edge.
*/
`timescale 1ns/100ps
module cbc_frame_src (
	input wire logic clock, // Clock
	input wire logic rst, // Reset
	input wire logic run, // Keep frames coming
	input wire logic [7:0] r_in, // Red level
	input wire logic [7:0] g_in, // Green and blue level
	output logic frame_start, // First pixel
	output logic frame_end, // Cycle after last pixel
	output logic pix_valid, // Pixel valid
	output logic [15:0] pix_x, // Column
	output logic [15:0] pix_y, // Row
	output logic [7:0] pix_r, // Red
	output logic [7:0] pix_g, // Green
	output logic [7:0] pix_b // Blue
);
	logic act_reg;
	logic [3:0] cnt_reg;
	// ----------------------------------------
	// Frame timing: 8 pixels, end pulse, three idle cycles
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			act_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end
		else
		begin
			act_reg <= act_reg ? (cnt_reg != 4'ha) : run;
			cnt_reg <= act_reg ? cnt_reg + 4'h1 : 4'h0;
		end
	end
	assign pix_valid = act_reg && (cnt_reg < 4'h8);
	assign frame_start = act_reg && (cnt_reg == 4'h0);
	assign frame_end = act_reg && (cnt_reg == 4'h8);
	assign pix_x = {14'h0, cnt_reg[1:0]};
	assign pix_y = {15'h0, cnt_reg[2]};
	// Idle data is inverted so stale values are never mistaken for pixels
	assign pix_r = pix_valid ? r_in : ~r_in;
	assign pix_g = pix_valid ? g_in : ~g_in;
	assign pix_b = pix_valid ? ((pix_x == 16'h0) ? 8'hff : g_in) : ~g_in;
endmodule : cbc_frame_src

// ### sim/testbench.sv
/*
 Testbench of the colour balance controller: register tasks, one task per scenario.
 Assumes the controller is built with a short stall timeout.
*/
`timescale 1ns/100ps
module testbench;
	import cbc_pkg::*;
	localparam int TO = 200;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_addr = CBC_REG_ADDR;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] rdata;
	logic rack, fs, fe, pv, freq, txf, crs, busy;
	logic [11:0] abs_ub = 12'h0aa;
	logic [11:0] abs_vr = 12'h033;
	logic [11:0] gu, gv, gg;
	logic [15:0] px, py;
	logic [7:0] pr, pg, pb;
	logic [7:0] r_lvl = 8'h40;
	logic stream_on = 1'b1;
	logic cap_on = 1'b1;
	logic run = 1'b0;
	logic win_en = 1'b0;
	logic [15:0] win_x = 16'h0;
	logic [15:0] win_w = 16'h4;
	logic [15:0] win_h = 16'h2;
	int fail_count = 0;
	int tests_run = 0;
	always #2.5 clock = ~clock;
	cbc_frame_src u_src (.clock(clock), .rst(rst), .run(run | freq), .r_in(r_lvl),
		.g_in(8'h40), .frame_start(fs), .frame_end(fe), .pix_valid(pv), .pix_x(px),
		.pix_y(py), .pix_r(pr), .pix_g(pg), .pix_b(pb));
	cbc_color_balance #(.TIMEOUT_CYC(TO)) u_dut (.clock(clock), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
		.reg_rack(rack), .abs_ub(abs_ub), .abs_vr(abs_vr), .stream_transmit_enable(stream_on),
		.capture_active(cap_on), .frame_start(fs), .frame_end(fe), .pix_valid(pv),
		.pix_x(px), .pix_y(py), .pix_r(pr), .pix_g(pg), .pix_b(pb), .window_enable(win_en),
		.win_x(win_x), .win_y(16'h0), .win_w(win_w), .win_h(win_h), .img_x(16'h0),
		.img_y(16'h0), .img_w(16'h4), .img_h(win_h), .gain_ub(gu), .gain_vr(gv),
		.gain_green(gg), .frame_request(freq), .transmit_frames(txf),
		.capture_restart(crs), .balance_busy(busy));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	function automatic logic [31:0] w(input logic a, input logic [2:0] m,
		input logic [11:0] u, input logic [11:0] v);
		return {1'b0, a, 3'h0, m, u, v};
	endfunction : w
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clock) #1;
	endtask : tick
	task automatic wr(input logic [31:0] d);
		tick(1);
		reg_wr = 1'b1;
		reg_wdata = d;
		tick(1);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		tick(1);
		reg_rd = 1'b1;
		reg_addr = a;
		tick(1);
		reg_rd = 1'b0;
		reg_addr = CBC_REG_ADDR;
		chk(rack, 1'b1);
		chk(rdata, exp);
	endtask : rd
	task automatic frames(input int n);
		int k;
		k = 0;
		run = 1'b1;
		repeat (400)
		begin
			tick(1);
			if (fe === 1'b1)
				k++;
			if (k == n)
				break;
		end
		run = 1'b0;
		chk(k, n);
		tick(12);
	endtask : frames
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(CBC_REG_ADDR, 32'h8011c11c);
		rd(CBC_REG_ADDR + 32'h4, 32'h0);
		wr(w(1'b0, 3'b010, 12'h100, 12'h050));
		rd(CBC_REG_ADDR, 32'h8211c11c);
		wr(w(1'b0, 3'b010, 12'h100, 12'h050));
		tick(1);
		chk({gu, gv, gg}, 36'h100050050);
		wr(w(1'b0, 3'b010, 12'hfff, 12'h050));
		tick(1);
		chk({gu, gg}, 24'h23811c);
		wr(w(1'b1, 3'b010, 12'h238, 12'h050));
		tick(1);
		chk({gu, gv}, {abs_ub, abs_vr});
		rd(CBC_REG_ADDR, 32'hc2238050);
		$display("test registers finished");
	endtask : t_regs
	task automatic t_oneshot;
		int n;
		logic rs;
		n = 0;
		rs = 1'b0;
		wr(w(1'b0, 3'b010, CBC_GAIN_MID, CBC_GAIN_MID));
		wr(w(1'b0, 3'b110, CBC_GAIN_MID, CBC_GAIN_MID));
		chk({busy, freq, txf}, 3'h7);
		rd(CBC_REG_ADDR, 32'h8611c11c);
		repeat (300)
		begin
			tick(1);
			if (fe === 1'b1)
				n++;
			if (crs === 1'b1)
				rs = 1'b1;
			if (busy !== 1'b1)
				break;
		end
		chk(n, 9);
		chk({rs, txf}, 2'h2);
		tick(2);
		rd(CBC_REG_ADDR, 32'h8211311c);
		$display("test one-shot finished");
	endtask : t_oneshot
	task automatic t_auto;
		r_lvl = 8'h30;
		cap_on = 1'b0;
		// Window set but disabled: a block that used it anyway would see equal blue and green sums
		win_x = 16'h1;
		win_w = 16'h3;
		wr(w(1'b0, 3'b111, 12'h113, 12'h11c));
		tick(1);
		chk(busy, 1'b0);
		frames(3);
		chk({gu, gv}, 24'h11011f);
		wr(w(1'b0, 3'b011, 12'h000, 12'h000));
		rd(CBC_REG_ADDR, 32'h8311011f);
		r_lvl = 8'h40;
		win_en = 1'b1;
		frames(2);
		chk({gu, gv}, 24'h11011f);
		tick(TO + 20);
		rd(CBC_REG_ADDR, 32'h8211011f);
		$display("test continuous finished");
	endtask : t_auto
	task automatic t_quiet;
		logic rs;
		rs = 1'b0;
		stream_on = 1'b0;
		cap_on = 1'b0;
		wr(w(1'b0, 3'b110, CBC_GAIN_MID, CBC_GAIN_MID));
		chk({busy, txf}, 2'h2);
		repeat (300)
		begin
			tick(1);
			if (crs === 1'b1)
				rs = 1'b1;
			if (busy !== 1'b1)
				break;
		end
		tick(1);
		chk({busy, rs, crs}, 3'h0);
		$display("test quiet one-shot finished");
	endtask : t_quiet
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial
	begin
		#100000;
		fail_count++;
		finish_test();
	end
	initial
	begin
		tick(16);
		rst = 1'b0;
		t_regs();
		t_oneshot();
		t_auto();
		t_quiet();
		finish_test();
	end
endmodule : testbench
